// ==== dv/bkcr_buck1_ctrl_tb.sv ====
// Self-checking testbench of the buck1 control register bank
`timescale 1ns/10ps
module bkcr_buck1_ctrl_tb;
	import bkcr_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sm_reset = 1'b0;
	logic [15:0] mask_ctrl_reset = 16'h4c25;
	logic [15:0] mask_slot_reset = 16'h1234;
	logic [15:0] mask_hib_reset = 16'h5aa5;
	logic [3:0] start_now = 4'h0;
	logic [3:0] stop_now = 4'h0;
	logic enter_active = 1'b0;
	logic enter_off = 1'b0;
	logic conv_enabled = 1'b0;
	logic active_mode_reg = 1'b1;
	logic sleep_ldo_reg = 1'b0;
	logic [3:0] hib_src = 4'h0;
	logic gpio_hib = 1'b0;
	logic conv_fault = 1'b0;
	logic [15:0] rdata;
	logic [6:0] vsel_out;
	logic [1:0] out_cap_range;
	logic ovp_dis, discharge_en, standby_force, ldo_force, conv_out_disable, hibernating;
	logic start_req, stop_req, fault_irq, fault_conv_off, fault_sys_off, cap_code_invalid;
	logic [7:0] vsel_steps_mv25;
	int err_count = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [7:0] ofs [3] = '{BKCR_OUTPUT_CONTROL_OFS, BKCR_SEQUENCING_SLOTS_OFS, 8'hb6};
	logic [15:0] msk [3] = '{16'hcc7f, 16'hffc0, 16'h737f};
	logic [15:0] rst [3] = '{16'h4c25, 16'h1200, 16'h5225};
	logic [3:0] slots [5] = '{4'h0, 4'h1, 4'h7, 4'he, 4'hf};

	// Clock of 100 ns period
	initial
	begin
		forever #50 clk = ~clk;
	end

	// ----------------------------------------
	// Device under test
	// ----------------------------------------
	bkcr_buck1_ctrl DUT (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sm_reset(sm_reset), .mask_ctrl_reset(mask_ctrl_reset),
		.mask_slot_reset(mask_slot_reset), .mask_hib_reset(mask_hib_reset),
		.seq_startup_slot_now(start_now), .seq_enter_active(enter_active),
		.seq_shutdown_slot_now(stop_now), .seq_enter_off(enter_off),
		.conv_enabled(conv_enabled), .active_mode_reg(active_mode_reg),
		.sleep_ldo_reg(sleep_ldo_reg), .hibernate_reg_bit(hib_src[0]),
		.low_power_input_1(hib_src[1]), .low_power_input_2(hib_src[2]),
		.low_power_input_3(hib_src[3]), .gpio_hibernate_in(gpio_hib), .conv_fault(conv_fault),
		.vsel_out(vsel_out), .out_cap_range(out_cap_range), .over_volt_prot_dis(ovp_dis),
		.discharge_en(discharge_en), .standby_force(standby_force), .ldo_force(ldo_force),
		.conv_out_disable(conv_out_disable), .hibernating(hibernating),
		.start_req(start_req), .stop_req(stop_req), .fault_irq(fault_irq),
		.fault_conv_off(fault_conv_off), .fault_sys_off(fault_sys_off),
		.cap_code_invalid(cap_code_invalid), .vsel_steps_mv25(vsel_steps_mv25)
	);

	// ----------------------------------------
	// Access and check tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string msg);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp, msg);
	endtask

	// Let register and output stages land
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Hang guard, far above the expected run length
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			err_count++;
			test_done();
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		// Defaults, writable bits, unmapped place and state machine reset
		rd_chk(BKCR_OUTPUT_CONTROL_OFS, 16'h000e, "ctrl default");
		rd_chk(BKCR_SEQUENCING_SLOTS_OFS, 16'h0000, "slot default");
		rd_chk(BKCR_HIBERNATE_SETTINGS_OFS, 16'h1006, "hib default");
		for (int i = 0; i < 3; i++)
		begin
			wr_reg(ofs[i], 16'hffff);
			rd_chk(ofs[i], msk[i], "writable bits");
		end
		wr_reg(8'hb7, 16'h1234);
		rd_chk(8'hb7, 16'h0000, "unmapped read");
		chk(ovp_dis, 16'h1, "protection disable set");
		@(posedge clk) sm_reset <= 1'b1;
		@(posedge clk) sm_reset <= 1'b0;
		for (int i = 0; i < 3; i++)
			rd_chk(ofs[i], rst[i], "state machine reset");
		// Capacitor range, discharge choice and voltage code
		for (int c = 0; c < 4; c++)
		begin
			wr_reg(BKCR_OUTPUT_CONTROL_OFS, {c[1:0], 3'h0, c[0], 3'h0, 7'h11 + 7'(c)});
			settle();
			chk(out_cap_range, 16'(c), "cap range");
			chk(cap_code_invalid, c == 2, "cap unused");
			chk(discharge_en, !c[0], "discharge");
			chk(ovp_dis, 16'h0, "protection disable clear");
			chk(vsel_out, 16'h11 + 16'(c), "voltage code");
			chk(vsel_steps_mv25, 16'h11 + 16'(c), "voltage steps");
		end
		wr_reg(BKCR_OUTPUT_CONTROL_OFS, 16'h0065);
		settle();
		chk(vsel_out, 16'h65, "code below top");
		wr_reg(BKCR_OUTPUT_CONTROL_OFS, 16'h0067);
		@(posedge clk) conv_enabled <= 1'b1;
		settle();
		chk(vsel_out, 16'h66, "code above top");
		chk(discharge_en, 16'h0, "no discharge when enabled");
		// Fault actions
		for (int a = 0; a < 4; a++)
		begin
			wr_reg(BKCR_SEQUENCING_SLOTS_OFS, 16'(a << 14));
			@(posedge clk) conv_fault <= 1'b1;
			settle();
			chk(fault_irq, 16'h1, "fault irq");
			chk(fault_conv_off, a == 1, "fault conv off");
			chk(fault_sys_off, a >= 2, "fault sys off");
			@(posedge clk) conv_fault <= 1'b0;
			settle();
			chk(fault_irq, 16'h0, "fault irq idle");
		end
		// Start-up and shutdown slots
		for (int i = 0; i < 5; i++)
		begin
			wr_reg(BKCR_SEQUENCING_SLOTS_OFS, {2'h0, slots[i], slots[i], 6'h00});
			@(posedge clk) start_now <= slots[i];
			@(posedge clk) stop_now <= slots[i];
			settle();
			chk(start_req, slots[i] >= 1 && slots[i] <= 14, "start in slot");
			chk(stop_req, slots[i] >= 1 && slots[i] <= 14, "stop in slot");
			@(posedge clk) start_now <= 4'h0;
			@(posedge clk) stop_now <= 4'h0;
			@(posedge clk) enter_active <= 1'b1;
			@(posedge clk) enter_off <= 1'b1;
			settle();
			chk(start_req, slots[i] == 15, "start on active");
			chk(stop_req, slots[i] == 0 || slots[i] == 15, "stop on off");
			@(posedge clk) enter_active <= 1'b0;
			@(posedge clk) enter_off <= 1'b0;
		end
		// Hibernate source selection, unselected sources asserted
		wr_reg(BKCR_OUTPUT_CONTROL_OFS, 16'h0010);
		for (int t = 0; t < 4; t++)
		begin
			wr_reg(BKCR_HIBERNATE_SETTINGS_OFS, {1'b0, 3'h1, 2'h0, t[1:0], 1'b0, 7'h20});
			@(posedge clk) hib_src <= 4'(1 << t);
			settle();
			chk(hibernating, 16'h1, "selected source");
			chk(vsel_out, 16'h20, "image code");
			@(posedge clk) hib_src <= ~4'(1 << t);
			settle();
			chk(hibernating, 16'h0, "other sources");
			chk(vsel_out, 16'h10, "normal code back");
			@(posedge clk) hib_src <= 4'h0;
		end
		@(posedge clk) gpio_hib <= 1'b1;
		settle();
		chk(hibernating, 16'h1, "pin hibernate");
		@(posedge clk) gpio_hib <= 1'b0;
		// Hibernate behaviour codes and restoration
		for (int m = 0; m < 8; m++)
		begin
			wr_reg(BKCR_HIBERNATE_SETTINGS_OFS, {1'b0, m[2:0], 4'h0, 1'b0, 7'h20});
			@(posedge clk) hib_src <= 4'h1;
			settle();
			chk(vsel_out, (m == 1 || m == 3 || m == 5) ? 16'h20 : 16'h10, "hib code");
			chk(standby_force, m == 2 || m == 3, "hib standby");
			chk(ldo_force, m == 4 || m == 5, "hib ldo");
			chk(conv_out_disable, m == 7, "hib off");
			@(posedge clk) hib_src <= 4'h0;
			settle();
			chk(vsel_out, 16'h10, "restore code");
			chk({standby_force, ldo_force, conv_out_disable}, 16'h0, "restore mode");
		end
		// Normal mode bits rule once hibernate is over
		@(posedge clk) active_mode_reg <= 1'b0;
		sleep_ldo_reg <= 1'b1;
		settle();
		chk({standby_force, ldo_force}, 16'h3, "normal mode bits");
		test_done();
	end
endmodule // bkcr_buck1_ctrl_tb

// ==== src/bkcr_buck1_ctrl.sv ====
// Buck1 control register bank with hibernate, fault and slot decoding
`timescale 1ns/10ps
module bkcr_buck1_ctrl
	import bkcr_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Power state machine
	input wire logic sm_reset,
	input wire logic [15:0] mask_ctrl_reset,
	input wire logic [15:0] mask_slot_reset,
	input wire logic [15:0] mask_hib_reset,
	input wire logic [3:0] seq_startup_slot_now,
	input wire logic seq_enter_active,
	input wire logic [3:0] seq_shutdown_slot_now,
	input wire logic seq_enter_off,
	input wire logic conv_enabled,
	input wire logic active_mode_reg,
	input wire logic sleep_ldo_reg,
	// Hibernate sources
	input wire logic hibernate_reg_bit,
	input wire logic low_power_input_1,
	input wire logic low_power_input_2,
	input wire logic low_power_input_3,
	input wire logic gpio_hibernate_in,
	// Fault
	input wire logic conv_fault,
	// Converter controls
	output logic [6:0] vsel_out,
	output logic [1:0] out_cap_range,
	output logic over_volt_prot_dis,
	output logic discharge_en,
	output logic standby_force,
	output logic ldo_force,
	output logic conv_out_disable,
	output logic hibernating,
	output logic start_req,
	output logic stop_req,
	output logic fault_irq,
	output logic fault_conv_off,
	output logic fault_sys_off,
	output logic cap_code_invalid,
	output logic [7:0] vsel_steps_mv25
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	bkcr_cfg_if cfg ();

	bkcr_regfile u_regs (
		.clk(clk),
		.rstn(rstn),
		.sm_reset(sm_reset),
		.mask_ctrl_reset(mask_ctrl_reset),
		.mask_slot_reset(mask_slot_reset),
		.mask_hib_reset(mask_hib_reset),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.cfg(cfg.regs)
	);

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	// Clamp a voltage code to the highest usable setting
	function automatic logic [6:0] vclamp(input logic [6:0] code);
		vclamp = (code > BKCR_VCODE_MAX) ? BKCR_VCODE_MAX : code;
	endfunction

	wire logic [6:0] normal_voltage_code = cfg.ctrl[BKCR_VSEL_LSB +: 7];
	wire logic [1:0] cap_field = cfg.ctrl[BKCR_CAP_LSB +: 2];
	wire logic float_on_disable = cfg.ctrl[BKCR_FLOAT_BIT];
	wire logic disovp = cfg.ctrl[BKCR_DISOVP_BIT];
	wire logic [1:0] fault_action = cfg.slot[BKCR_ERRACT_LSB +: 2];
	wire logic [3:0] startup_slot = cfg.slot[BKCR_ENSLOT_LSB +: 4];
	wire logic [3:0] shutdown_slot = cfg.slot[BKCR_SDSLOT_LSB +: 4];
	wire logic [2:0] hibernate_behaviour = cfg.hib[BKCR_HIBMODE_LSB +: 3];
	wire logic [1:0] hibernate_source_select = cfg.hib[BKCR_HIBTRIG_LSB +: 2];
	wire logic [6:0] image_voltage_code = cfg.hib[BKCR_VIMG_LSB +: 7];

	// Hibernate source selection
	wire logic hib_sel = (hibernate_source_select == BKCR_TRIG_REG) ? hibernate_reg_bit :
		(hibernate_source_select == BKCR_TRIG_LP1) ? low_power_input_1 :
		(hibernate_source_select == BKCR_TRIG_LP2) ? low_power_input_2 : low_power_input_3;
	wire logic hib_now = hib_sel || gpio_hibernate_in;

	// Hibernate behaviour decode; outside hibernate only the normal settings count
	wire logic use_image = hib_now && (
		hibernate_behaviour == BKCR_HIB_IMG || hibernate_behaviour == BKCR_HIB_STBY_IMG ||
		hibernate_behaviour == BKCR_HIB_LDO_IMG);
	wire logic stby_d = hib_now && (hibernate_behaviour == BKCR_HIB_STBY ||
		hibernate_behaviour == BKCR_HIB_STBY_IMG);
	wire logic ldo_d = hib_now && (hibernate_behaviour == BKCR_HIB_LDO ||
		hibernate_behaviour == BKCR_HIB_LDO_IMG);
	wire logic off_d = hib_now && (hibernate_behaviour == BKCR_HIB_OFF);
	wire logic [6:0] vsel_d = use_image ? vclamp(image_voltage_code) :
		vclamp(normal_voltage_code);
	wire logic enabled_d = conv_enabled && !off_d;
	// Outside hibernate the mode bits of the state machine decide standby again
	wire logic standby_d = stby_d || (!hib_now && !active_mode_reg);

	// Sequencer slot decode
	wire logic start_d = (startup_slot != BKCR_SLOT_NEVER) &&
		((startup_slot == BKCR_SLOT_ACTIVE) ? seq_enter_active :
		(seq_startup_slot_now == startup_slot));
	wire logic sd_at_off = (shutdown_slot == BKCR_SLOT_NEVER) ||
		(shutdown_slot == BKCR_SLOT_ACTIVE);
	wire logic stop_d = sd_at_off ? seq_enter_off : (seq_shutdown_slot_now == shutdown_slot);

	// Fault action decode
	wire logic fconv_d = conv_fault && (fault_action == BKCR_ERR_CONV);
	wire logic fsys_d = conv_fault && (fault_action != BKCR_ERR_IGNORE) &&
		(fault_action != BKCR_ERR_CONV);

	// Read mux
	wire logic [15:0] rd_d = (addr == BKCR_OUTPUT_CONTROL_OFS) ? cfg.ctrl :
		(addr == BKCR_SEQUENCING_SLOTS_OFS) ? cfg.slot :
		(addr == BKCR_HIBERNATE_SETTINGS_OFS) ? cfg.hib : 16'h0000;

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	// Converter drive
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			vsel_out <= 7'h00;
			out_cap_range <= 2'h0;
			over_volt_prot_dis <= 1'b0;
			discharge_en <= 1'b0;
			standby_force <= 1'b0;
			ldo_force <= 1'b0;
			conv_out_disable <= 1'b1;
			hibernating <= 1'b0;
			cap_code_invalid <= 1'b0;
			vsel_steps_mv25 <= 8'h00;
		end
		else
		begin
			vsel_out <= vsel_d;
			out_cap_range <= cap_field;
			cap_code_invalid <= (cap_field == BKCR_CAP_UNUSED);
			over_volt_prot_dis <= disovp;
			discharge_en <= !enabled_d && !float_on_disable;
			standby_force <= standby_d;
			ldo_force <= ldo_d || (!hib_now && sleep_ldo_reg);
			conv_out_disable <= !enabled_d;
			hibernating <= hib_now;
			vsel_steps_mv25 <= {1'b0, vsel_d};
		end
	end

	// Sequencer and fault requests, registered one cycle after their conditions and held while they last
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			start_req <= 1'b0;
			stop_req <= 1'b0;
			fault_irq <= 1'b0;
			fault_conv_off <= 1'b0;
			fault_sys_off <= 1'b0;
		end
		else
		begin
			start_req <= start_d;
			stop_req <= stop_d;
			fault_irq <= conv_fault;
			fault_conv_off <= fconv_d;
			fault_sys_off <= fsys_d;
		end
	end

	// Read data the cycle after the strobe
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rdata <= 16'h0000;
		else if (rd)
			rdata <= rd_d;
		else
			rdata <= 16'h0000;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_hib_image;
		hib_now && use_image;
	endsequence

	chk_vsel_cap_max: assert property (@(posedge clk) disable iff (!rstn)
		vsel_out <= BKCR_VCODE_MAX)
		else $error("voltage code above maximum");
	chk_cap_unused_flag: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> cap_code_invalid == ($past(cap_field) == BKCR_CAP_UNUSED))
		else $error("unused capacitor code not flagged");
	chk_discharge_float: assert property (@(posedge clk) disable iff (!rstn)
		(!enabled_d && float_on_disable) |=> !discharge_en)
		else $error("floating output was discharged");
	chk_fault_irq_always: assert property (@(posedge clk) disable iff (!rstn)
		conv_fault |=> fault_irq && !(fault_conv_off && fault_sys_off))
		else $error("fault did not raise interrupt");
	chk_start_never: assert property (@(posedge clk) disable iff (!rstn)
		(startup_slot == BKCR_SLOT_NEVER) |=> !start_req)
		else $error("start with slot zero");
	chk_stop_at_off: assert property (@(posedge clk) disable iff (!rstn)
		(sd_at_off && seq_enter_off) |=> stop_req)
		else $error("no shutdown on entering off");
	chk_image_applied: assert property (@(posedge clk) disable iff (!rstn)
		s_hib_image |=> vsel_out == vclamp($past(image_voltage_code)))
		else $error("image voltage not applied");
	chk_hib_disable_out: assert property (@(posedge clk) disable iff (!rstn)
		(hib_now && hibernate_behaviour == BKCR_HIB_OFF) |=> conv_out_disable)
		else $error("output not disabled in hibernate");
	chk_gpio_hib_force: assert property (@(posedge clk) disable iff (!rstn)
		gpio_hibernate_in |=> hibernating)
		else $error("gpio hibernate ignored");
	chk_hib_exit_normal: assert property (@(posedge clk) disable iff (!rstn)
		(!hib_now) |=> vsel_out == vclamp($past(normal_voltage_code)) &&
		standby_force == !$past(active_mode_reg) && ldo_force == $past(sleep_ldo_reg))
		else $error("normal settings not restored");

	// Named steps of the slot and fault behaviour
	sequence s_start_slot_hit;
		(startup_slot != BKCR_SLOT_NEVER) && (startup_slot != BKCR_SLOT_ACTIVE) &&
		(seq_startup_slot_now == startup_slot);
	endsequence
	sequence s_stop_slot_hit;
		!sd_at_off && (seq_shutdown_slot_now == shutdown_slot);
	endsequence
	sequence s_fault_sys;
		conv_fault && (fault_action != BKCR_ERR_IGNORE) && (fault_action != BKCR_ERR_CONV);
	endsequence

	// Voltage code and capacitor field
	chk_steps_match: assert property (@(posedge clk) disable iff (!rstn)
		vsel_steps_mv25 == {1'b0, vsel_out})
		else $error("step count differs from voltage code");
	chk_cap_field_out: assert property (@(posedge clk) disable iff (!rstn)
		1'b1 |=> out_cap_range == $past(cap_field))
		else $error("capacitor range not passed on");

	// Discharge on disable
	chk_discharge_on_dis: assert property (@(posedge clk) disable iff (!rstn)
		(!enabled_d && !float_on_disable) |=> discharge_en)
		else $error("disabled output not discharged");
	chk_no_discharge_en: assert property (@(posedge clk) disable iff (!rstn)
		enabled_d |=> !discharge_en)
		else $error("running output discharged");

	// Fault actions
	chk_fault_conv_only: assert property (@(posedge clk) disable iff (!rstn)
		(conv_fault && fault_action == BKCR_ERR_CONV) |=> fault_conv_off && !fault_sys_off)
		else $error("converter shutdown action wrong");
	chk_fault_sys_only: assert property (@(posedge clk) disable iff (!rstn)
		s_fault_sys |=> fault_sys_off && !fault_conv_off)
		else $error("system shutdown action wrong");
	chk_fault_ignore: assert property (@(posedge clk) disable iff (!rstn)
		(conv_fault && fault_action == BKCR_ERR_IGNORE) |=> !fault_conv_off && !fault_sys_off)
		else $error("ignored fault caused shutdown");
	chk_fault_idle: assert property (@(posedge clk) disable iff (!rstn)
		!conv_fault |=> !fault_irq && !fault_conv_off && !fault_sys_off)
		else $error("fault output without fault");

	// Start-up and shutdown slots
	chk_start_in_slot: assert property (@(posedge clk) disable iff (!rstn)
		s_start_slot_hit |=> start_req)
		else $error("no start in own slot");
	chk_start_on_active: assert property (@(posedge clk) disable iff (!rstn)
		(startup_slot == BKCR_SLOT_ACTIVE && seq_enter_active) |=> start_req)
		else $error("no start on entering active");
	chk_start_active_wait: assert property (@(posedge clk) disable iff (!rstn)
		(startup_slot == BKCR_SLOT_ACTIVE && !seq_enter_active) |=> !start_req)
		else $error("start before entering active");
	chk_stop_in_slot: assert property (@(posedge clk) disable iff (!rstn)
		s_stop_slot_hit |=> stop_req)
		else $error("no shutdown in own slot");
	chk_stop_off_wait: assert property (@(posedge clk) disable iff (!rstn)
		(sd_at_off && !seq_enter_off) |=> !stop_req)
		else $error("shutdown before entering off");

	// Hibernate behaviour codes
	chk_standby_forced: assert property (@(posedge clk) disable iff (!rstn)
		(hib_now && (hibernate_behaviour == BKCR_HIB_STBY ||
		hibernate_behaviour == BKCR_HIB_STBY_IMG)) |=> standby_force)
		else $error("standby not forced in hibernate");
	chk_keep_normal: assert property (@(posedge clk) disable iff (!rstn)
		(hib_now && (hibernate_behaviour == BKCR_HIB_KEEP ||
		hibernate_behaviour == BKCR_HIB_RSVD)) |=> vsel_out == vclamp($past(normal_voltage_code)))
		else $error("kept settings changed voltage");
	chk_ldo_forced: assert property (@(posedge clk) disable iff (!rstn)
		(hib_now && (hibernate_behaviour == BKCR_HIB_LDO ||
		hibernate_behaviour == BKCR_HIB_LDO_IMG)) |=> ldo_force)
		else $error("low-dropout mode not forced");
	chk_out_enabled: assert property (@(posedge clk) disable iff (!rstn)
		(conv_enabled && !(hib_now && hibernate_behaviour == BKCR_HIB_OFF)) |=> !conv_out_disable)
		else $error("enabled output held off");

	// Hibernate sources
	chk_src_reg_bit: assert property (@(posedge clk) disable iff (!rstn)
		(hibernate_source_select == BKCR_TRIG_REG && hibernate_reg_bit) |=> hibernating)
		else $error("software hibernate bit ignored");
	chk_src_low_power3: assert property (@(posedge clk) disable iff (!rstn)
		(hibernate_source_select != BKCR_TRIG_REG && hibernate_source_select != BKCR_TRIG_LP1 &&
		hibernate_source_select != BKCR_TRIG_LP2 && low_power_input_3) |=> hibernating)
		else $error("third low-power input ignored");
	chk_hib_release: assert property (@(posedge clk) disable iff (!rstn)
		(!hib_sel && !gpio_hibernate_in) |=> !hibernating)
		else $error("hibernate without a source");
endmodule // bkcr_buck1_ctrl

// ==== src/bkcr_cfg_if.sv ====
// Interface carrying the three raw configuration register words between modules
`timescale 1ns/10ps
interface bkcr_cfg_if;
	import bkcr_pkg::*;
	logic [15:0] ctrl;
	logic [15:0] slot;
	logic [15:0] hib;
	modport regs (output ctrl, output slot, output hib);
	modport user (input ctrl, input slot, input hib);
endinterface

// ==== src/bkcr_pkg.sv ====
// Package with register map, field layout and encodings of the buck1 control bank
package bkcr_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] BKCR_OUTPUT_CONTROL_OFS = 8'hb4;
	localparam logic [7:0] BKCR_SEQUENCING_SLOTS_OFS = 8'hb5;
	localparam logic [7:0] BKCR_HIBERNATE_SETTINGS_OFS = 8'hb6;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BKCR_CAP_LSB = 14;
	localparam int BKCR_DISOVP_BIT = 11;
	localparam int BKCR_FLOAT_BIT = 10;
	localparam int BKCR_VSEL_LSB = 0;
	localparam int BKCR_ERRACT_LSB = 14;
	localparam int BKCR_ENSLOT_LSB = 10;
	localparam int BKCR_SDSLOT_LSB = 6;
	localparam int BKCR_HIBMODE_LSB = 12;
	localparam int BKCR_HIBTRIG_LSB = 8;
	localparam int BKCR_VIMG_LSB = 0;
	// Writable bit masks of each register
	localparam logic [15:0] BKCR_CTRL_MASK = 16'hcc7f;
	localparam logic [15:0] BKCR_SLOT_MASK = 16'hffc0;
	localparam logic [15:0] BKCR_HIB_MASK = 16'h737f;
	// ----------------------------------------
	// Default values
	// ----------------------------------------
	localparam logic [15:0] BKCR_CTRL_RESET = 16'h000e;
	localparam logic [15:0] BKCR_SLOT_RESET = 16'h0000;
	localparam logic [15:0] BKCR_HIB_RESET = 16'h1006;
	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [6:0] BKCR_VCODE_MAX = 7'h66;
	localparam logic [1:0] BKCR_CAP_UNUSED = 2'h2;
	localparam logic [3:0] BKCR_SLOT_NEVER = 4'h0;
	localparam logic [3:0] BKCR_SLOT_ACTIVE = 4'hf;
	localparam logic [1:0] BKCR_ERR_IGNORE = 2'h0;
	localparam logic [1:0] BKCR_ERR_CONV = 2'h1;
	localparam logic [1:0] BKCR_TRIG_REG = 2'h0;
	localparam logic [1:0] BKCR_TRIG_LP1 = 2'h1;
	localparam logic [1:0] BKCR_TRIG_LP2 = 2'h2;
	typedef enum logic [2:0] {
		BKCR_HIB_KEEP = 3'h0,
		BKCR_HIB_IMG = 3'h1,
		BKCR_HIB_STBY = 3'h2,
		BKCR_HIB_STBY_IMG = 3'h3,
		BKCR_HIB_LDO = 3'h4,
		BKCR_HIB_LDO_IMG = 3'h5,
		BKCR_HIB_RSVD = 3'h6,
		BKCR_HIB_OFF = 3'h7
	} bkcr_hib_t;
endpackage

// ==== src/bkcr_regfile.sv ====
// Register storage for the three buck1 control words with bus write access
`timescale 1ns/10ps
module bkcr_regfile
	import bkcr_pkg::*;
(
	// Clock and resets
	input wire logic clk,
	input wire logic rstn,
	input wire logic sm_reset,
	input wire logic [15:0] mask_ctrl_reset,
	input wire logic [15:0] mask_slot_reset,
	input wire logic [15:0] mask_hib_reset,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	// Fields out
	bkcr_cfg_if.regs cfg
);
	logic [15:0] ctrl_q;
	logic [15:0] slot_q;
	logic [15:0] hib_q;
	wire logic wr_ctrl = wr && (addr == BKCR_OUTPUT_CONTROL_OFS);
	wire logic wr_slot = wr && (addr == BKCR_SEQUENCING_SLOTS_OFS);
	wire logic wr_hib = wr && (addr == BKCR_HIBERNATE_SETTINGS_OFS);

	// Storage; the state machine reset wins over a write
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_q <= BKCR_CTRL_RESET;
			slot_q <= BKCR_SLOT_RESET;
			hib_q <= BKCR_HIB_RESET;
		end
		else if (sm_reset)
		begin
			ctrl_q <= mask_ctrl_reset & BKCR_CTRL_MASK;
			slot_q <= mask_slot_reset & BKCR_SLOT_MASK;
			hib_q <= mask_hib_reset & BKCR_HIB_MASK;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= wdata & BKCR_CTRL_MASK;
			if (wr_slot)
				slot_q <= wdata & BKCR_SLOT_MASK;
			if (wr_hib)
				hib_q <= wdata & BKCR_HIB_MASK;
		end
	end

	assign cfg.ctrl = ctrl_q;
	assign cfg.slot = slot_q;
	assign cfg.hib = hib_q;

	chk_sm_reset_loads: assert property (@(posedge clk) disable iff (!rstn)
		sm_reset |=> ctrl_q == $past(mask_ctrl_reset & BKCR_CTRL_MASK))
		else $error("control word not restored by state machine reset");
	chk_sm_reset_slot: assert property (@(posedge clk) disable iff (!rstn)
		sm_reset |=> slot_q == $past(mask_slot_reset & BKCR_SLOT_MASK))
		else $error("slot word not restored by state machine reset");
	chk_sm_reset_hib: assert property (@(posedge clk) disable iff (!rstn)
		sm_reset |=> hib_q == $past(mask_hib_reset & BKCR_HIB_MASK))
		else $error("hibernate word not restored by state machine reset");
endmodule // bkcr_regfile
